// ==== reading_output_formatter.v ====
// Operation
// - ASCII code 1: each reading goes out as a 15-byte text field
// - Short integer code 2: 16-bit two's complement, two bytes
// - Long integer code 3: 32-bit two's complement, four bytes
// - Single float code 4: 32-bit IEEE-754, four bytes
// - Double float code 5: 64-bit IEEE-754, eight bytes
// - Reset or select command without argument chooses ASCII
// - ASCII readings end with CR LF; binary encodings never add it
// - With end signalling enabled, EOI marks the last byte sent
// - Group recall in ASCII: comma between readings, CR LF once at end
// - No commas for direct, implied-read or binary readings
// - Short integer overload gives unscaled +32767 or -32768
// - Long integer overload gives unscaled signed 32-bit extreme
// - ASCII and float overload give 1.0E+38 with overload sign
// - Sub-sampling with memory disabled forces short integer
// - Query answers are ASCII; readings keep the selected encoding
// - Bus encoding is independent of the memory storage encoding
// - Integer encodings scale readings; factor reported by query
// - Encoding query reports current encoding, including forced one
`timescale 1ns/100ps
`default_nettype none
`include "rof_regs.vh"

module reading_output_formatter (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  // Encoding control
  input  wire        fmt_set_i,
  input  wire        fmt_arg_present_i,
  input  wire [2:0]  fmt_arg_i,
  input  wire        subsample_i,
  input  wire        mem_enabled_i,
  input  wire        eoi_enable_i,
  input  wire [5:0]  scale_shift_i,
  output wire [2:0]  out_encoding_o,
  // Reading stream
  input  wire        rdg_valid_i,
  output wire        rdg_ready_o,
  input  wire [119:0] rdg_ascii_i,
  input  wire [47:0] rdg_count_i,
  input  wire [31:0] rdg_single_i,
  input  wire [63:0] rdg_double_i,
  input  wire        rdg_ovld_i,
  input  wire        rdg_ovld_neg_i,
  input  wire        rdg_recall_i,
  input  wire        rdg_last_i,
  // Queries
  input  wire        qry_valid_i,
  input  wire        qry_sel_i,
  output wire        qry_ready_o,
  // Bus byte stream
  output wire        tx_valid_o,
  output wire [7:0]  tx_data_o,
  output wire        tx_eoi_o,
  input  wire        tx_ready_i
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg  [2:0]           encoding_r;
  reg                  state_r;
  reg  [`FRAME_W-1:0]  frame_r;
  reg  [`FRAME_W-1:0]  frame_nxt;
  reg  [4:0]           cnt_r;
  reg  [4:0]           len_nxt;
  reg                  eoi_end_r;
  reg                  end_nxt;
  wire                 take_qry;
  wire                 take_rdg;
  wire                 fifo_in_ready;
  wire                 fifo_push;
  wire [8:0]           fifo_out;
  wire [47:0]          scaled;
  wire [15:0]          short_val;
  wire [31:0]          long_val;
  wire                 group_mid;
  wire [7:0]           sign_chr;
  wire [119:0]         text_field;
  wire [5:0]           tens;
  wire [5:0]           ones;
  wire                 fifo_out_valid;
  wire                 fifo_out_ready;
  reg                  tx_valid_r;
  reg  [7:0]           tx_data_r;
  reg                  tx_eoi_r;

  assign out_encoding_o = encoding_r;

  // Encoding select; sub-sampling wins over a same-cycle select
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      encoding_r <= `ENC_RESET;
    end else if (subsample_i && !mem_enabled_i) begin
      encoding_r <= `ENC_SHORT;
    end else if (fmt_set_i) begin
      if (!fmt_arg_present_i) begin
        encoding_r <= `ENC_ASCII;
      end else if (fmt_arg_i >= `ENC_ASCII &&
                   fmt_arg_i <= `ENC_DOUBLE) begin
        encoding_r <= fmt_arg_i;
      end
    end
  end

  // Memory storage encoding lives elsewhere and is never touched here

  // Integer scaling by a power of two set by function and range
  assign scaled = $signed(rdg_count_i) >>> scale_shift_i;

  int_saturate #(
    .W      (16)
  ) u_sat_short (
    .val_i  (scaled),
    .ovld_i (rdg_ovld_i),
    .neg_i  (rdg_ovld_neg_i),
    .val_o  (short_val)
  );

  int_saturate #(
    .W      (32)
  ) u_sat_long (
    .val_i  (scaled),
    .ovld_i (rdg_ovld_i),
    .neg_i  (rdg_ovld_neg_i),
    .val_o  (long_val)
  );

  // Only a non-final reading of a recalled group continues the line
  assign group_mid  = rdg_recall_i && !rdg_last_i;
  assign sign_chr   = rdg_ovld_neg_i ? `CHR_MINUS : `CHR_PLUS;
  assign text_field = rdg_ovld_i ? {sign_chr, `OVL_ASCII_TAIL}
                                 : rdg_ascii_i;
  assign tens       = scale_shift_i / 6'h0A;
  assign ones       = scale_shift_i % 6'h0A;

  // Queries take precedence over a waiting reading; a reading already being sent finishes first
  assign qry_ready_o = (state_r == ST_IDLE);
  assign rdg_ready_o = (state_r == ST_IDLE) && !qry_valid_i;
  assign take_qry    = qry_valid_i && qry_ready_o;
  assign take_rdg    = rdg_valid_i && rdg_ready_o;

  always @* begin
    frame_nxt = {`FRAME_W{1'b0}};
    len_nxt   = 5'h00;
    end_nxt   = 1'b1;
    if (take_qry) begin
      // Answers are text whatever the reading encoding
      if (qry_sel_i == `QRY_ENC) begin
        frame_nxt = {`CHR_ZERO + {5'h00, encoding_r}, `CHR_CR, `CHR_LF,
                     112'h0};
        len_nxt   = `LEN_QRY_ENC;
      end else begin
        // Factor is 2 to the minus this two-digit power
        frame_nxt = {`CHR_ZERO + {2'b00, tens}, `CHR_ZERO + {2'b00, ones},
                     `CHR_CR, `CHR_LF, 104'h0};
        len_nxt   = `LEN_QRY_SCALE;
      end
    end else begin
      end_nxt = !group_mid;
      case (encoding_r)
        `ENC_ASCII: begin
          if (group_mid) begin
            frame_nxt = {text_field, `CHR_COMMA, 8'h00};
            len_nxt   = `LEN_ASCII + `LEN_COMMA;
          end else begin
            frame_nxt = {text_field, `CHR_CR, `CHR_LF};
            len_nxt   = `LEN_ASCII + `LEN_EOL;
          end
        end
        `ENC_SHORT: begin
          frame_nxt = {short_val, 120'h0};
          len_nxt   = `LEN_SHORT;
        end
        `ENC_LONG: begin
          frame_nxt = {long_val, 104'h0};
          len_nxt   = `LEN_LONG;
        end
        `ENC_SINGLE: begin
          if (rdg_ovld_i) begin
            frame_nxt = {rdg_ovld_neg_i, `OVL_SINGLE_MAG,
                         104'h0};
          end else begin
            frame_nxt = {rdg_single_i, 104'h0};
          end
          len_nxt = `LEN_SINGLE;
        end
        `ENC_DOUBLE: begin
          if (rdg_ovld_i) begin
            frame_nxt = {rdg_ovld_neg_i, `OVL_DOUBLE_MAG,
                         72'h0};
          end else begin
            frame_nxt = {rdg_double_i, 72'h0};
          end
          len_nxt = `LEN_DOUBLE;
        end
        default: begin
          frame_nxt = {`FRAME_W{1'b0}};
          len_nxt   = 5'h00;
        end
      endcase
    end
  end

  // Serialiser: top byte first, stalls while the FIFO is full
  assign fifo_push = (state_r == ST_SEND);

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= ST_IDLE;
      frame_r   <= {`FRAME_W{1'b0}};
      cnt_r     <= 5'h00;
      eoi_end_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if ((take_qry || take_rdg) && len_nxt != 5'h00) begin
            frame_r   <= frame_nxt;
            cnt_r     <= len_nxt;
            eoi_end_r <= end_nxt && eoi_enable_i;
            state_r   <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (fifo_in_ready) begin
            frame_r <= {frame_r[`FRAME_W-9:0], 8'h00};
            cnt_r   <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  byte_fifo #(
    .W           (9),
    .DEPTH       (8),
    .AW          (3)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({eoi_end_r && (cnt_r == 5'h01),
                   frame_r[`FRAME_W-1:`FRAME_W-8]}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out)
  );

  // Output stage keeps the bus pins on flops; costs one cycle of latency
  assign fifo_out_ready = !tx_valid_r || tx_ready_i;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_eoi_r   <= 1'b0;
    end else if (fifo_out_ready) begin
      tx_valid_r <= fifo_out_valid;
      tx_data_r  <= fifo_out[7:0];
      tx_eoi_r   <= fifo_out[8];
    end
  end

  assign tx_valid_o = tx_valid_r;
  assign tx_data_o  = tx_data_r;
  assign tx_eoi_o   = tx_eoi_r;

endmodule

`default_nettype wire

// ==== rof_regs.vh ====
`ifndef ROF_REGS_VH
`define ROF_REGS_VH

// Encoding codes, as reported by the encoding query
`define ENC_ASCII      3'h1
`define ENC_SHORT      3'h2
`define ENC_LONG       3'h3
`define ENC_SINGLE     3'h4
`define ENC_DOUBLE     3'h5
`define ENC_RESET      3'h1

// Byte counts per frame
`define LEN_ASCII      5'h0F
`define LEN_SHORT      5'h02
`define LEN_LONG       5'h04
`define LEN_SINGLE     5'h04
`define LEN_DOUBLE     5'h08
`define LEN_EOL        5'h02
`define LEN_COMMA      5'h01
`define LEN_QRY_ENC    5'h03
`define LEN_QRY_SCALE  5'h04

// Characters
`define CHR_CR         8'h0D
`define CHR_LF         8'h0A
`define CHR_COMMA      8'h2C
`define CHR_ZERO       8'h30
`define CHR_PLUS       8'h2B
`define CHR_MINUS      8'h2D

// Overload values: float magnitudes of 1.0E+38, text "1.00000000E+38"
`define OVL_SINGLE_MAG 31'h7E967699
`define OVL_DOUBLE_MAG 63'h47D2CED32A16A1B1
`define OVL_ASCII_TAIL 112'h312E3030303030303030452B3338

// Query selectors
`define QRY_ENC        1'b0
`define QRY_SCALE      1'b1

// Frame buffer: 15 text bytes plus line end
`define FRAME_W        136

`endif

// ==== byte_fifo.v ====
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter W     = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire         clk_sys_i,
  input  wire         rst_n_i,
  // Fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // Drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);

  localparam [AW:0] DEPTH_C = DEPTH[AW:0];

  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready_o  = (cnt_r != DEPTH_C);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== int_saturate.v ====
`timescale 1ns/100ps
`default_nettype none

module int_saturate #(
  parameter W = 16
) (
  // Scaled reading
  input  wire [47:0]  val_i,
  input  wire         ovld_i,
  input  wire         neg_i,
  // Integer result
  output reg  [W-1:0] val_o
);

  wire [W-1:0] pos_max = {1'b0, {(W-1){1'b1}}};
  wire [W-1:0] neg_min = {1'b1, {(W-1){1'b0}}};
  // In range when all bits above the sign of the result agree with it
  wire         fits    = (val_i[47:W-1] == {(49-W){val_i[W-1]}});

  always @* begin
    if (ovld_i) begin
      val_o = neg_i ? neg_min : pos_max;
    end else if (!fits) begin
      // Out of range without overload: clamp rather than wrap
      val_o = val_i[47] ? neg_min : pos_max;
    end else begin
      val_o = val_i[W-1:0];
    end
  end

endmodule

`default_nettype wire

// ==== bus_listener.sv ====
`timescale 1ns/100ps
`default_nettype none
module bus_listener (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Byte handshake
  input  wire logic slow_i,
  output var  logic tx_ready_o
);
  // Slow mode is ready every other cycle so the FIFO fills
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      tx_ready_o <= 1'b0;
    else
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
  end
endmodule
`default_nettype wire

// ==== rof_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module rof_props (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       fmt_set_i,
  input wire logic       fmt_arg_present_i,
  input wire logic [2:0] fmt_arg_i,
  input wire logic       subsample_i,
  input wire logic       mem_enabled_i,
  input wire logic [2:0] out_encoding_o,
  input wire logic       rdg_valid_i,
  input wire logic       rdg_ready_o,
  input wire logic       qry_valid_i,
  input wire logic       qry_ready_o,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_eoi_o,
  input wire logic       tx_ready_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire sub_f  = subsample_i && !mem_enabled_i;
  wire arg_ok = fmt_arg_i != 3'h0 && fmt_arg_i < 3'h6;
  wire set_a  = fmt_set_i && fmt_arg_present_i && !subsample_i;
  wire nd_a   = fmt_set_i && !fmt_arg_present_i && !sub_f;
  wire rdg_go = rdg_valid_i && rdg_ready_o;
  a_reset_ascii: assert property (
    $rose(rst_n_i) |-> out_encoding_o == 3'h1)
    else $error("encoding not text after reset");
  a_noarg_ascii: assert property (
    nd_a |=> out_encoding_o == 3'h1)
    else $error("no-argument select wrong");
  a_sub_force: assert property (
    sub_f |=> out_encoding_o == 3'h2)
    else $error("sub-sampling did not force short integer");
  a_set_code: assert property (
    set_a && arg_ok |=> out_encoding_o == $past(fmt_arg_i))
    else $error("encoding not taken");
  a_bad_keep: assert property (
    set_a && !arg_ok |=> $stable(out_encoding_o))
    else $error("bad code changed encoding");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i
      |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_eoi_o))
    else $error("byte dropped while stalled");
  // Load, FIFO write, then the output stage: three edges
  a_first_byte: assert property (
    rdg_go |-> ##3 tx_valid_o)
    else $error("first byte late");
  a_query_wins: assert property (
    qry_valid_i |-> !rdg_ready_o)
    else $error("reading taken beside query");
  c_rdg: cover property (rdg_go);
  c_qry: cover property (qry_valid_i && qry_ready_o);
  c_sub: cover property (sub_f);
endmodule
bind reading_output_formatter rof_props u_props (.clk_sys_i, .rst_n_i,
  .fmt_set_i, .fmt_arg_present_i, .fmt_arg_i, .subsample_i, .mem_enabled_i,
  .out_encoding_o, .rdg_valid_i, .rdg_ready_o, .qry_valid_i, .qry_ready_o,
  .tx_valid_o, .tx_data_o, .tx_eoi_o, .tx_ready_i);
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [2:0]  e;
    logic [5:0]  sh;
    logic        o;
    logic        n;
    logic [63:0] v;
    logic [63:0] x;
    logic [3:0]  l;
  } row_t;
  logic clk_sys_i = 0, rst_n_i = 0, fmt_set_i = 0, fmt_arg_present_i = 0;
  logic subsample_i = 0, mem_enabled_i = 0, eoi_enable_i = 1, slow = 0;
  logic rdg_valid_i = 0, rdg_ovld_i = 0, rdg_ovld_neg_i = 0;
  logic rdg_recall_i = 0, rdg_last_i = 0, qry_valid_i = 0, qry_sel_i = 0;
  logic [2:0]   fmt_arg_i = 0;
  logic [5:0]   scale_shift_i = 0;
  logic [119:0] rdg_ascii_i = "+1.23456789E+00";
  logic [47:0]  rdg_count_i = 0;
  logic [31:0]  rdg_single_i = 0;
  logic [63:0]  rdg_double_i = 0;
  wire  [2:0]   out_encoding_o;
  wire  [7:0]   tx_data_o;
  wire          rdg_ready_o, qry_ready_o, tx_valid_o, tx_eoi_o, tx_ready_i;
  logic [7:0]   rq[$];
  logic         eq[$];
  int           checks = 0, err_count = 0, k;
  row_t         r;
  row_t rows[10] = '{
    '{3'h2, 6'h0, 1'b0, 1'b0, 64'h1234, 64'h1234, 4'h2},
    '{3'h2, 6'h4, 1'b0, 1'b0, 64'h10000, 64'h1000, 4'h2},
    '{3'h2, 6'h4, 1'b1, 1'b0, 64'h0, 64'h7FFF, 4'h2},
    '{3'h2, 6'h0, 1'b1, 1'b1, 64'h0, 64'h8000, 4'h2},
    '{3'h3, 6'h0, 1'b0, 1'b0, 64'hFFFFFEDCBA98, 64'hFEDCBA98,
      4'h4},
    '{3'h3, 6'h4, 1'b1, 1'b1, 64'h0, 64'h80000000, 4'h4},
    '{3'h4, 6'h0, 1'b0, 1'b0, 64'h3FC00000, 64'h3FC00000,
      4'h4},
    '{3'h4, 6'h0, 1'b1, 1'b1, 64'h0, 64'hFE967699, 4'h4},
    '{3'h5, 6'h0, 1'b0, 1'b0, 64'h400921FB54442D18,
      64'h400921FB54442D18, 4'h8},
    '{3'h5, 6'h0, 1'b1, 1'b0, 64'h0, 64'h47D2CED32A16A1B1,
      4'h8}};
  reading_output_formatter dut (.*);
  bus_listener u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .slow_i(slow), .tx_ready_o(tx_ready_i));
  always #10 clk_sys_i = ~clk_sys_i;
  // Settled half a cycle before the edge that completes the handshake
  always @(negedge clk_sys_i) begin
    if (tx_valid_o && tx_ready_i) begin
      rq.push_back(tx_data_o);
      eq.push_back(tx_eoi_o);
    end
  end
  task chk(input string nm, input logic [63:0] ex, got);
    checks++;
    if (ex !== got) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task take(input int n, input logic [135:0] ex, input logic ee);
    int i;
    i = 0;
    while (rq.size() < n && i < 200) begin
      @(negedge clk_sys_i);
      i++;
    end
    // Quiet spell shows up any stray trailing byte
    repeat (6) @(negedge clk_sys_i);
    chk("count", n, rq.size());
    for (i = 0; i < n; i++) chk("byte", ex[8*(n-1-i) +: 8], rq[i]);
    chk("eoi", ee, eq[n-1]);
    rq = {};
    eq = {};
  endtask
  task setf(input logic a, input logic [2:0] c);
    @(negedge clk_sys_i);
    fmt_set_i = 1;
    fmt_arg_present_i = a;
    fmt_arg_i = c;
    @(negedge clk_sys_i);
    fmt_set_i = 0;
  endtask
  task rd(input logic rc, input logic lt);
    @(negedge clk_sys_i);
    rdg_valid_i = 1;
    rdg_recall_i = rc;
    rdg_last_i = lt;
    while (!rdg_ready_o) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    rdg_valid_i = 0;
  endtask
  task qry(input logic s);
    @(negedge clk_sys_i);
    qry_valid_i = 1;
    qry_sel_i = s;
    while (!qry_ready_o) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    qry_valid_i = 0;
  endtask
  task sub(input logic m);
    @(negedge clk_sys_i);
    mem_enabled_i = m;
    subsample_i = 1;
    @(negedge clk_sys_i);
    subsample_i = 0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (3) @(negedge clk_sys_i);
    rst_n_i = 1;
    chk("enc", 3'h1, out_encoding_o);
    for (k = 0; k < 10; k++) begin
      r = rows[k];
      slow = k[0];
      setf(1, r.e);
      chk("enc", r.e, out_encoding_o);
      scale_shift_i = r.sh;
      rdg_ovld_i = r.o;
      rdg_ovld_neg_i = r.n;
      rdg_count_i = r.v[47:0];
      rdg_single_i = r.v[31:0];
      rdg_double_i = r.v;
      rd(0, 1);
      take(r.l, r.x, 1);
    end
    $display("binary rows done");
    rdg_ovld_i = 0;
    slow = 1;
    setf(0, 3'h4);
    chk("enc", 3'h1, out_encoding_o);
    rd(0, 1);
    take(17, {rdg_ascii_i, 8'h0D, 8'h0A}, 1);
    rd(1, 0);
    take(16, {rdg_ascii_i, 8'h2C}, 0);
    rd(1, 1);
    take(17, {rdg_ascii_i, 8'h0D, 8'h0A}, 1);
    eoi_enable_i = 0;
    rdg_ovld_i = 1;
    rdg_ovld_neg_i = 1;
    rd(0, 1);
    take(17, {"-1.00000000E+38", 8'h0D, 8'h0A}, 0);
    $display("text readings done");
    eoi_enable_i = 1;
    rdg_ovld_i = 0;
    setf(1, 3'h3);
    qry(0);
    take(3, {8'h33, 8'h0D, 8'h0A}, 1);
    scale_shift_i = 6'h0C;
    qry(1);
    take(4, {"12", 8'h0D, 8'h0A}, 1);
    scale_shift_i = 0;
    rdg_count_i = 48'h5;
    rd(0, 1);
    take(4, 64'h5, 1);
    @(negedge clk_sys_i);
    rdg_valid_i = 1;
    qry_valid_i = 1;
    qry_sel_i = 0;
    @(negedge clk_sys_i);
    qry_valid_i = 0;
    while (!rdg_ready_o) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    rdg_valid_i = 0;
    take(7, {8'h33, 8'h0D, 8'h0A, 32'h5}, 1);
    setf(1, 3'h7);
    chk("enc", 3'h3, out_encoding_o);
    sub(1);
    chk("enc", 3'h3, out_encoding_o);
    sub(0);
    chk("enc", 3'h2, out_encoding_o);
    rst_n_i = 0;
    @(negedge clk_sys_i);
    rst_n_i = 1;
    chk("enc", 3'h1, out_encoding_o);
    $display("control tests done");
    give_verdict;
  end
endmodule
`default_nettype wire
